// file: inc/alarm_pkg.sv
// Constants, register map and carrier types for the alarm latch block.
// Assumes a classic Wishbone slave with 32-bit data on one 100 MHz clock.
// Contract
// - Critical lamp amber by default, red when configuration selects red.
// - Critical alarm set and cleared only by bus; connector cannot clear.
// - Major amber or red; bus sets; bus or connector pulse clears.
// - Minor lamp always amber; bus sets; bus or connector clears.
// - Power lamp amber; set by bus or by system fault line.
// - Power alarm cleared only by bus command, never by fault or connector.
// - Major relay energised while major alarm active.
// - Minor relay energised while minor alarm active.
// - Power relay energised while power alarm active.
// - Four relays, all controlled by management controller bus transactions.
// - Critical, major, minor relays are changeover (common, NO, NC).
// - Power relay has common and normally-open contact only.
// - Clear inputs exist for major and minor only.
// - Critical and major drive separate red and yellow lamps by colour.
// - Module drives a fitted indication toward the front panel.
package alarm_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM   = 8'h00;
  localparam logic [7:0] ADDR_SET     = 8'h04;
  localparam logic [7:0] ADDR_CLEAR   = 8'h08;
  localparam logic [7:0] ADDR_CONFIG  = 8'h0C;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h10;
  localparam logic [7:0] ADDR_IRQMASK = 8'h14;
  localparam logic [7:0] ADDR_ID      = 8'h18;

  // Alarm bit positions
  localparam int BIT_CRIT  = 0;
  localparam int BIT_MAJOR = 1;
  localparam int BIT_MINOR = 2;
  localparam int BIT_POWER = 3;
  localparam int NUM_ALARMS = 4;

  // Config bit positions
  localparam int CFG_CRIT_RED  = 0;
  localparam int CFG_MAJOR_RED = 1;

  // Interrupt status bit positions
  localparam int IRQ_FAULT     = 0;
  localparam int IRQ_MAJOR_CLR = 1;
  localparam int IRQ_MINOR_CLR = 2;
  localparam int NUM_IRQ       = 3;

  // Reset values
  localparam logic [3:0] ALARM_RESET   = 4'h0;
  localparam logic [1:0] CONFIG_RESET  = 2'h0;
  localparam logic [2:0] IRQ_RESET     = 3'h0;

  // Arbitrary identification value, names no maker or part
  localparam logic [31:0] MODULE_ID = 32'h00A1_0001;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Relay drive: 1 energises the coil
  typedef struct packed {
    logic critical;
    logic major;
    logic minor;
    logic power;
  } relay_t;

  // Front panel lamps, active low
  typedef struct packed {
    logic critical_alarm_red_lamp_n;
    logic critical_alarm_yellow_lamp_n;
    logic major_alarm_red_lamp_n;
    logic major_alarm_yellow_lamp_n;
    logic minor_alarm_lamp_n;
    logic power_alarm_lamp_n;
    logic alarm_module_fitted_n;
  } lamps_t;

endpackage : alarm_pkg

// file: rtl/clear_edge_detect.sv
// Two-flop synchroniser and falling-edge detector for one pin.
// Assumes the pin is asynchronous to sys_clk; output pulse is one cycle.
`timescale 1ns/1ps
module clear_edge_detect (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic pinLevel_n,
  output logic      fallPulse
);
  logic meta;
  logic syncd;
  logic prev;

  // Pin idles high; falling edge is a clear request
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta  <= 1'b1;
      syncd <= 1'b1;
      prev  <= 1'b1;
    end else begin
      meta  <= pinLevel_n;
      syncd <= meta;
      prev  <= syncd;
    end
  end

  assign fallPulse = prev & ~syncd;

  a_one_cycle_pulse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    fallPulse |=> !fallPulse)
    else $error("clear pulse longer than one cycle");

endmodule : clear_edge_detect

// file: rtl/telco_alarm_latch_relay.sv
// Alarm latches, lamp and relay drive, Wishbone register slave.
// Assumes classic Wishbone master on sys_clk; fault and clear pins async.
`timescale 1ns/1ps
module telco_alarm_latch_relay (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire alarm_pkg::wb_req_t    wbReq,
  output alarm_pkg::wb_rsp_t         wbRsp,
  input  wire logic                  system_fault_line_n,
  input  wire logic                  major_clear_in_n,
  input  wire logic                  minor_clear_in_n,
  output alarm_pkg::relay_t          relayDrive,
  output alarm_pkg::lamps_t          lamps,
  output logic                       irq
);
  import alarm_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic faultMeta;
  logic faultSync;
  logic majorClearPulse;
  logic minorClearPulse;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      faultMeta <= 1'b1;
      faultSync <= 1'b1;
    end else begin
      faultMeta <= system_fault_line_n;
      faultSync <= faultMeta;
    end
  end

  // Only major and minor have connector clear inputs
  clear_edge_detect majorClearDet (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pinLevel_n (major_clear_in_n),
    .fallPulse  (majorClearPulse)
  );

  clear_edge_detect minorClearDet (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pinLevel_n (minor_clear_in_n),
    .fallPulse  (minorClearPulse)
  );

  wire faultActive = ~faultSync;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic ack;
  logic [NUM_ALARMS-1:0] alarm;
  logic [1:0]            colourCfg;
  logic [NUM_IRQ-1:0]    irqStat;
  logic [NUM_IRQ-1:0]    irqMask;
  logic [31:0]           readData;

  // Single-cycle ack; no ack while the previous one is still high
  wire access   = wbReq.cyc & wbReq.stb & ~ack;
  wire wrAccess = access & wbReq.we & wbReq.sel[0];
  wire wrSet    = wrAccess & (wbReq.adr == ADDR_SET);
  wire wrClear  = wrAccess & (wbReq.adr == ADDR_CLEAR);
  wire wrAlarm  = wrAccess & (wbReq.adr == ADDR_ALARM);
  wire wrConfig = wrAccess & (wbReq.adr == ADDR_CONFIG);
  wire wrIrqSt  = wrAccess & (wbReq.adr == ADDR_IRQSTAT);
  wire wrIrqMk  = wrAccess & (wbReq.adr == ADDR_IRQMASK);
  wire [3:0] wrBits = wbReq.dat[3:0];

  // Writing ALARM loads all four latches, but an active fault line keeps power set; SET/CLEAR act bitwise
  wire [3:0] busSet = wrSet ? wrBits :
                      (wrAlarm ? wrBits : 4'h0);
  wire [3:0] busClr = wrClear ? wrBits :
                      (wrAlarm ? ~wrBits : 4'h0);

  // ----------------------------------------------------------------------
  // Alarm latches
  // ----------------------------------------------------------------------
  // Set wins over clear so a fresh event is never lost
  wire [3:0] setReq;
  wire [3:0] clrReq;
  assign setReq[BIT_CRIT]  = busSet[BIT_CRIT];
  assign clrReq[BIT_CRIT]  = busClr[BIT_CRIT];
  assign setReq[BIT_MAJOR] = busSet[BIT_MAJOR];
  assign clrReq[BIT_MAJOR] = busClr[BIT_MAJOR] | majorClearPulse;
  assign setReq[BIT_MINOR] = busSet[BIT_MINOR];
  assign clrReq[BIT_MINOR] = busClr[BIT_MINOR] | minorClearPulse;
  assign setReq[BIT_POWER] = busSet[BIT_POWER] | faultActive;
  assign clrReq[BIT_POWER] = busClr[BIT_POWER];

  wire [3:0] next_alarm = setReq | (alarm & ~clrReq);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      alarm <= ALARM_RESET;
    end else begin
      alarm <= next_alarm;
    end
  end

  // ----------------------------------------------------------------------
  // Colour configuration
  // ----------------------------------------------------------------------
  // Changed only by an explicit configuration write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      colourCfg <= CONFIG_RESET;
    end else if (wrConfig) begin
      colourCfg <= wbReq.dat[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  wire [NUM_IRQ-1:0] irqEvent = {minorClearPulse, majorClearPulse,
                                 faultActive};
  wire [NUM_IRQ-1:0] irqClr   = wrIrqSt ? wbReq.dat[NUM_IRQ-1:0] : 3'h0;
  wire [NUM_IRQ-1:0] next_irqStat = irqEvent | (irqStat & ~irqClr);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irqStat <= IRQ_RESET;
      irqMask <= IRQ_RESET;
    end else begin
      irqStat <= next_irqStat;
      if (wrIrqMk) begin
        irqMask <= wbReq.dat[NUM_IRQ-1:0];
      end
    end
  end

  assign irq = |(irqStat & irqMask);

  // ----------------------------------------------------------------------
  // Read path and ack
  // ----------------------------------------------------------------------
  wire mapped = (wbReq.adr == ADDR_ALARM)   | (wbReq.adr == ADDR_SET)  |
                (wbReq.adr == ADDR_CLEAR)   | (wbReq.adr == ADDR_CONFIG) |
                (wbReq.adr == ADDR_IRQSTAT) | (wbReq.adr == ADDR_IRQMASK) |
                (wbReq.adr == ADDR_ID);

  // Unmapped reads return zero; writes to them are dropped but acked
  wire [31:0] rdMux =
    (wbReq.adr == ADDR_ALARM)   ? {28'h000_0000, alarm}     :
    (wbReq.adr == ADDR_CONFIG)  ? {30'h0000_0000, colourCfg} :
    (wbReq.adr == ADDR_IRQSTAT) ? {29'h0000_0000, irqStat}   :
    (wbReq.adr == ADDR_IRQMASK) ? {29'h0000_0000, irqMask}   :
    (wbReq.adr == ADDR_ID)      ? MODULE_ID                 :
                                  32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack      <= 1'b0;
      readData <= 32'h0000_0000;
    end else begin
      ack      <= access;
      readData <= (access & mapped) ? rdMux : 32'h0000_0000;
    end
  end

  assign wbRsp.ack = ack;
  assign wbRsp.dat = readData;

  // ----------------------------------------------------------------------
  // Relays and lamps
  // ----------------------------------------------------------------------
  // Each relay follows its latch; contact wiring is on the board
  logic [3:0]  relayReg;
  lamps_t      lampReg;

  wire critOn  = alarm[BIT_CRIT];
  wire majorOn = alarm[BIT_MAJOR];
  wire minorOn = alarm[BIT_MINOR];
  wire powerOn = alarm[BIT_POWER];
  wire critRed  = colourCfg[CFG_CRIT_RED];
  wire majorRed = colourCfg[CFG_MAJOR_RED];

  // Lamps registered so they move in the same cycle as the relays
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      relayReg <= 4'h0;
      lampReg  <= 7'h7E;
    end else begin
      relayReg <= next_alarm;
      lampReg.critical_alarm_red_lamp_n    <=
        ~(next_alarm[BIT_CRIT] & critRed);
      lampReg.critical_alarm_yellow_lamp_n <=
        ~(next_alarm[BIT_CRIT] & ~critRed);
      lampReg.major_alarm_red_lamp_n       <=
        ~(next_alarm[BIT_MAJOR] & majorRed);
      lampReg.major_alarm_yellow_lamp_n    <=
        ~(next_alarm[BIT_MAJOR] & ~majorRed);
      lampReg.minor_alarm_lamp_n <= ~next_alarm[BIT_MINOR];
      lampReg.power_alarm_lamp_n <= ~next_alarm[BIT_POWER];
      lampReg.alarm_module_fitted_n <= 1'b0;
    end
  end

  // Relays 0..2 are changeover, power is make-only: one coil drive each
  assign relayDrive.critical = relayReg[BIT_CRIT];
  assign relayDrive.major    = relayReg[BIT_MAJOR];
  assign relayDrive.minor    = relayReg[BIT_MINOR];
  assign relayDrive.power    = relayReg[BIT_POWER];
  // Contact sets: critical/major/minor COMM+NO+NC, power COMM+NO only
  assign lamps = lampReg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_crit_set;
    wrSet && wrBits[BIT_CRIT];
  endsequence

  // One connector clear while the other latch is left alone
  sequence s_major_pin_only;
    majorClearPulse && !minorClearPulse && !busClr[BIT_MINOR];
  endsequence

  sequence s_minor_pin_only;
    minorClearPulse && !majorClearPulse && !busClr[BIT_MAJOR];
  endsequence

  a_crit_set_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_crit_set ##1 (!clrReq[BIT_CRIT]) |=> alarm[BIT_CRIT])
    else $error("critical alarm not held after set");

  a_crit_no_conn: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (alarm[BIT_CRIT] && !busClr[BIT_CRIT]) |=> alarm[BIT_CRIT])
    else $error("critical alarm cleared without bus command");

  a_major_conn_clr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (majorClearPulse && !busSet[BIT_MAJOR]) |=> !alarm[BIT_MAJOR])
    else $error("major alarm not cleared by connector");

  a_minor_conn_clr: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (minorClearPulse && !busSet[BIT_MINOR]) |=> !alarm[BIT_MINOR])
    else $error("minor alarm not cleared by connector");

  a_major_pin_own: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_major_pin_only ##0 alarm[BIT_MINOR] |=> alarm[BIT_MINOR])
    else $error("major clear pin disturbed the minor alarm");

  a_minor_pin_own: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_minor_pin_only ##0 alarm[BIT_MAJOR] |=> alarm[BIT_MAJOR])
    else $error("minor clear pin disturbed the major alarm");

  a_power_fault_set: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(faultSync) |=> alarm[BIT_POWER])
    else $error("fault line did not set power alarm");

  // Fault beats a bus clear in the same cycle
  a_power_fault_wins: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    faultActive |=> alarm[BIT_POWER])
    else $error("power alarm clear while fault line active");

  a_power_sticky: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (alarm[BIT_POWER] && !busClr[BIT_POWER]) |=> alarm[BIT_POWER])
    else $error("power alarm cleared without bus command");

  a_crit_relay: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    relayDrive.critical == alarm[BIT_CRIT])
    else $error("critical relay differs from alarm");

  a_major_relay: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    relayDrive.major == alarm[BIT_MAJOR])
    else $error("major relay differs from alarm");

  a_minor_relay: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    relayDrive.minor == alarm[BIT_MINOR])
    else $error("minor relay differs from alarm");

  a_power_relay: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    relayDrive.power == alarm[BIT_POWER])
    else $error("power relay differs from alarm");

  a_changeover_idle: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !(alarm[BIT_CRIT] | alarm[BIT_MAJOR] | alarm[BIT_MINOR]) |->
      !(relayDrive.critical | relayDrive.major | relayDrive.minor))
    else $error("changeover relay energised with no alarm");

  a_power_make_only: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    relayDrive.power |-> alarm[BIT_POWER])
    else $error("power relay energised with no power alarm");

  a_crit_colour: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    alarm[BIT_CRIT] |-> (lamps.critical_alarm_red_lamp_n
      != lamps.critical_alarm_yellow_lamp_n))
    else $error("critical lamps not exclusive");

  // Lamps pick up a new colour one cycle after the config write
  a_crit_amber: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    alarm[BIT_CRIT] && !critRed && $stable(colourCfg) |->
      !lamps.critical_alarm_yellow_lamp_n)
    else $error("critical alarm not amber by default");

  a_major_amber: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    alarm[BIT_MAJOR] && !majorRed && $stable(colourCfg) |->
      !lamps.major_alarm_yellow_lamp_n)
    else $error("major alarm not amber by default");

  a_cfg_write_only: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !wrConfig |=> $stable(colourCfg))
    else $error("colour changed without a config write");

  a_power_lamp: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    lamps.power_alarm_lamp_n == !alarm[BIT_POWER])
    else $error("power lamp differs from alarm");

  a_lamp_low: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !alarm[BIT_MINOR] |-> lamps.minor_alarm_lamp_n)
    else $error("minor lamp on while inactive");

  a_fitted_low: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $past(reset_n) |-> !lamps.alarm_module_fitted_n)
    else $error("fitted line not asserted");

  // Checked at the first edge after release, not during reset itself
  a_reset_clean: assert property (
    @(posedge sys_clk)
    reset_n && $past(!reset_n) |-> (alarm == 4'h0 && relayReg == 4'h0))
    else $error("alarms active after reset");

  a_ack_one: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ack |=> !ack)
    else $error("ack held longer than one cycle");

  a_ack_answer: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    access |=> ack)
    else $error("request not answered in the next cycle");

endmodule : telco_alarm_latch_relay

// file: test/mgmt_ctrl_model.sv
// Management controller model: classic Wishbone master for the alarm block.
// Assumes the slave answers every request with a one-cycle ack on sys_clk.
`timescale 1ns/1ps
module mgmt_ctrl_model (
  output alarm_pkg::wb_req_t      wbReq,
  input  wire logic               sys_clk,
  input  wire alarm_pkg::wb_rsp_t wbRsp
);
  import alarm_pkg::*;

  initial wbReq = '0;

  // ------------------------------------------------------------------
  // One classic cycle
  // ------------------------------------------------------------------
  // Request held until ack is sampled high; the bound only guards a hang
  task automatic access(input  logic        we,
                        input  logic [7:0]  adr,
                        input  logic [31:0] wd,
                        output logic [31:0] rd,
                        output logic        ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF,
               adr: adr, dat: wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 64);
    ok = (wbRsp.ack === 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask : access
endmodule : mgmt_ctrl_model

// file: test/test_telco_alarm_latch_relay.sv
// Self-checking bench for the alarm latch, lamp and relay block.
// Assumes the management controller model drives the register bus.
`timescale 1ns/1ps
module test_telco_alarm_latch_relay;
  import alarm_pkg::*;

  logic       sys_clk;
  logic       reset_n;
  logic       faultLineN;
  logic       majorClrN;
  logic       minorClrN;
  wb_req_t    wbReq;
  wb_rsp_t    wbRsp;
  relay_t     relayDrive;
  lamps_t     lamps;
  logic       irq;
  int         n_mismatch;
  int         n_tests;
  logic [3:0] alarm;
  logic [1:0] cfg;

  telco_alarm_latch_relay u_dut (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .wbReq               (wbReq),
    .wbRsp               (wbRsp),
    .system_fault_line_n (faultLineN),
    .major_clear_in_n    (majorClrN),
    .minor_clear_in_n    (minorClrN),
    .relayDrive          (relayDrive),
    .lamps               (lamps),
    .irq                 (irq)
  );

  mgmt_ctrl_model u_host (
    .wbReq   (wbReq),
    .sys_clk (sys_clk),
    .wbRsp   (wbRsp)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------------
  // Reporting and compares
  // ------------------------------------------------------------------
  task automatic results;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkWord

  // Relays, lamps and irq against the expected latches and colours
  task automatic checkPins(input logic irqExp);
    logic [11:0] exp;
    exp = {alarm[0], alarm[1], alarm[2], alarm[3],
           ~(alarm[0] & cfg[0]), ~(alarm[0] & ~cfg[0]),
           ~(alarm[1] & cfg[1]), ~(alarm[1] & ~cfg[1]),
           ~alarm[2], ~alarm[3], 1'b0, irqExp};
    @(negedge sys_clk);
    checkWord({20'h0_0000, relayDrive, lamps, irq}, {20'h0_0000, exp});
  endtask : checkPins

  // ------------------------------------------------------------------
  // Bus and pin helpers
  // ------------------------------------------------------------------
  task automatic busIo(input  logic        we,
                       input  logic [7:0]  adr,
                       input  logic [31:0] wd,
                       output logic [31:0] rd);
    logic ok;
    u_host.access(we, adr, wd, rd, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error t=%0t bus timeout adr=%h", $time, adr);
      results();
    end
  endtask : busIo

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    busIo(1'b1, adr, wd, rd);
  endtask : wr

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    busIo(1'b0, adr, 32'h0000_0000, rd);
    checkWord(rd, exp);
  endtask : rdChk

  // Pin edges pass a synchroniser, so the settle time is bounded, not fixed
  task automatic waitRelay;
    int         n;
    logic [3:0] expRelay;
    n = 0;
    expRelay = {alarm[0], alarm[1], alarm[2], alarm[3]};
    while (relayDrive !== expRelay && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    if (relayDrive !== expRelay) begin
      n_mismatch++;
      $display("Error t=%0t relay got=%h exp=%h", $time, relayDrive,
               expRelay);
      results();
    end
  endtask : waitRelay

  task automatic pulsePin(input logic major);
    @(posedge sys_clk);
    if (major) begin
      majorClrN <= 1'b0;
    end else begin
      minorClrN <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    majorClrN <= 1'b1;
    minorClrN <= 1'b1;
  endtask : pulsePin

  task automatic doReset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : doReset

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic testReset;
    alarm = 4'h0;
    cfg = 2'h0;
    rdChk(ADDR_ALARM, 32'h0000_0000);
    rdChk(ADDR_CONFIG, 32'h0000_0000);
    rdChk(ADDR_ID, MODULE_ID);
    rdChk(8'h1C, 32'h0000_0000);
    rdChk(ADDR_IRQMASK, 32'h0000_0000);
    rdChk(ADDR_SET, 32'h0000_0000);
    checkPins(1'b0);
    $display("test reset done");
  endtask : testReset

  // Every alarm under every colour setting, set and cleared by bus
  task automatic testBusLatch;
    for (int c = 0; c < 4; c++) begin
      cfg = c[1:0];
      wr(ADDR_CONFIG, {30'h0, cfg});
      for (int b = 0; b < NUM_ALARMS; b++) begin
        alarm = 4'h0;
        alarm[b] = 1'b1;
        wr(ADDR_SET, {28'h000_0000, alarm});
        checkPins(1'b0);
        rdChk(ADDR_ALARM, {28'h000_0000, alarm});
        wr(ADDR_CLEAR, {28'h000_0000, alarm});
        alarm = 4'h0;
        checkPins(1'b0);
      end
    end
    alarm = 4'h5;
    wr(ADDR_ALARM, 32'h0000_0005);
    checkPins(1'b0);
    rdChk(ADDR_ALARM, 32'h0000_0005);
    alarm = 4'h0;
    wr(ADDR_ALARM, 32'h0000_0000);
    checkPins(1'b0);
    $display("test bus latch done");
  endtask : testBusLatch

  // Connector clears hit only their own latch; critical and power stay
  task automatic testConnClear;
    wr(ADDR_IRQMASK, 32'h0000_0004);
    wr(ADDR_SET, 32'h0000_000F);
    alarm = 4'hF;
    pulsePin(1'b1);
    alarm[1] = 1'b0;
    waitRelay();
    checkPins(1'b0);
    wr(ADDR_SET, 32'h0000_0002);
    alarm[1] = 1'b1;
    pulsePin(1'b0);
    alarm[2] = 1'b0;
    waitRelay();
    checkPins(1'b1);
    pulsePin(1'b1);
    alarm[1] = 1'b0;
    pulsePin(1'b0);
    repeat (8) @(posedge sys_clk);
    checkPins(1'b1);
    rdChk(ADDR_IRQSTAT, 32'h0000_0006);
    wr(ADDR_IRQSTAT, 32'h0000_0006);
    checkPins(1'b0);
    wr(ADDR_CLEAR, 32'h0000_000F);
    alarm = 4'h0;
    checkPins(1'b0);
    $display("test connector clear done");
  endtask : testConnClear

  // Fault line sets power; only a bus clear with the line idle removes it
  task automatic testFault;
    wr(ADDR_IRQMASK, 32'h0000_0001);
    @(posedge sys_clk);
    faultLineN <= 1'b0;
    alarm[3] = 1'b1;
    waitRelay();
    checkPins(1'b1);
    wr(ADDR_CLEAR, 32'h0000_0008);
    checkPins(1'b1);
    @(posedge sys_clk);
    faultLineN <= 1'b1;
    repeat (6) @(posedge sys_clk);
    checkPins(1'b1);
    wr(ADDR_IRQSTAT, 32'h0000_0001);
    checkPins(1'b0);
    wr(ADDR_CLEAR, 32'h0000_0008);
    alarm = 4'h0;
    checkPins(1'b0);
    $display("test fault line done");
  endtask : testFault

  initial begin
    reset_n = 1'b0;
    faultLineN = 1'b1;
    majorClrN = 1'b1;
    minorClrN = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    doReset();
    testReset();
    testBusLatch();
    testConnClear();
    testFault();
    wr(ADDR_CONFIG, 32'h0000_0003);
    wr(ADDR_SET, 32'h0000_000F);
    doReset();
    testReset();
    results();
  end
endmodule : test_telco_alarm_latch_relay
